// ---- inc/dyn_term_defines.vh ----
`ifndef DYN_TERM_DEFINES_VH
`define DYN_TERM_DEFINES_VH
// termination select encodings
`define TERM_OFF 2'h0
`define TERM_NOMINAL 2'h1
`define TERM_WRITE 2'h2
// latency offsets in clocks
`define NOM_TO_WR_SUB 6'h02
`define OFF_LAT_SUB 6'h02
`define WR_TO_NOM_CHOP 6'h04
`define WR_TO_NOM_FULL 6'h06
// feedback delay limit, in picoseconds and clock period
`define FEEDBACK_DELAY_PS 9000
`define FEEDBACK_DELAY_FAST_PS 7500
`define CLOCK_PERIOD_PS 100000
`define COUNT_W 6
`endif

// ---- rtl/leveling_feedback.v ----
`timescale 1ns/1ps
`include "dyn_term_defines.vh"
module leveling_feedback #(
    parameter DATA_W = 8
) (
    input wire clock,
    input wire rstn,
    input wire leveling_en,
    input wire strobe_rise,
    input wire clk_level,
    output reg [DATA_W-1:0] fb_data_q,
    output reg fb_oe_q
);
    // sample clock level on each rising strobe edge while leveling_en is set; the 9 ns limit is far below
    // one 100 ns cycle, so the feedback lands on the very next edge
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fb_data_q <= {DATA_W{1'b0}};
            fb_oe_q <= 1'b0;
        end else begin
            fb_oe_q <= leveling_en;
            if (leveling_en && strobe_rise) begin
                fb_data_q <= {DATA_W{clk_level}};
            end
        end
    end
endmodule // leveling_feedback

// ---- rtl/dyn_term.v ----
// What this block does
// - switch nominal to write termination write latency minus 2 after write
// - back to nominal after off latency plus 4 chop or plus 6 full
// - leveling feedback on data lines within 9 ns, 7.5 ns fastest grade
// - every cycle timing counts actual rising clock edges
// - off latency equals column write plus additive latency minus 2
`timescale 1ns/1ps
`include "dyn_term_defines.vh"
module dyn_term #(
    parameter DATA_W = 8
) (
    input wire clock,
    input wire rstn,
    input wire term_ctrl,
    input wire write_cmd,
    input wire four_beat_chop,
    input wire dyn_term_en,
    input wire [`COUNT_W-1:0] column_write_latency,
    input wire [`COUNT_W-1:0] additive_latency,
    input wire leveling_en,
    input wire strobe_rise,
    input wire clk_level,
    output reg [1:0] term_sel_q,
    output wire [DATA_W-1:0] fb_data,
    output wire fb_oe
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT_ON = 2'h1;
    localparam ST_WRITE = 2'h2;

    // feedback cycle bound, rounded down, at least one cycle
    localparam FB_CYC_RAW = `FEEDBACK_DELAY_FAST_PS / `CLOCK_PERIOD_PS;
    localparam FB_CYC = (FB_CYC_RAW < 1) ? 1 : FB_CYC_RAW;

    wire [`COUNT_W-1:0] write_latency;
    wire [`COUNT_W-1:0] nominal_to_write_term_latency;
    wire [`COUNT_W-1:0] termination_off_latency;
    wire [`COUNT_W-1:0] write_to_nominal_term_latency_chop;
    wire [`COUNT_W-1:0] write_to_nominal_term_latency_full;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [`COUNT_W-1:0] cnt_q;
    reg [`COUNT_W-1:0] cnt_d;
    reg [`COUNT_W-1:0] off_q;
    reg [`COUNT_W-1:0] off_d;
    reg [1:0] term_sel_d;
    wire dyn_ok;

    // latencies; clamps avoid underflow when latencies are set too small
    assign write_latency = column_write_latency + additive_latency;
    assign nominal_to_write_term_latency = (write_latency > `NOM_TO_WR_SUB) ?
        write_latency - `NOM_TO_WR_SUB : 6'h00;
    assign termination_off_latency = (write_latency > `OFF_LAT_SUB) ?
        write_latency - `OFF_LAT_SUB : 6'h00;
    assign write_to_nominal_term_latency_chop =
        termination_off_latency + `WR_TO_NOM_CHOP;
    assign write_to_nominal_term_latency_full =
        termination_off_latency + `WR_TO_NOM_FULL;
    assign dyn_ok = term_ctrl && dyn_term_en && !leveling_en;

    // counters advance once per rising clock edge, never by elapsed time
    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        off_d = off_q;
        term_sel_d = term_ctrl ? `TERM_NOMINAL : `TERM_OFF;
        if (term_sel_q == `TERM_WRITE) begin
            term_sel_d = `TERM_WRITE;
        end
        case (state_q)
            ST_IDLE: begin
                if (write_cmd && dyn_ok) begin
                    // precompute the chop or full return point, counted from the write
                    off_d = four_beat_chop ? write_to_nominal_term_latency_chop :
                        write_to_nominal_term_latency_full;
                    // the count holds the number of edges seen since the write edge
                    cnt_d = 6'h00;
                    state_d = ST_WAIT_ON;
                    if (nominal_to_write_term_latency == 6'h00) begin
                        term_sel_d = `TERM_WRITE;
                        state_d = ST_WRITE;
                    end
                end
            end
            ST_WAIT_ON: begin
                cnt_d = cnt_q + 6'h01;
                if (cnt_d >= nominal_to_write_term_latency) begin
                    term_sel_d = `TERM_WRITE;
                    state_d = ST_WRITE;
                end
            end
            ST_WRITE: begin
                cnt_d = cnt_q + 6'h01;
                if (cnt_d >= off_q) begin
                    term_sel_d = term_ctrl ? `TERM_NOMINAL : `TERM_OFF;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // a dropped enable aborts the dynamic change at once
        if (!dyn_term_en || leveling_en) begin
            state_d = ST_IDLE;
            term_sel_d = (term_ctrl && !leveling_en) ? `TERM_NOMINAL : `TERM_OFF;
        end
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            cnt_q <= 6'h00;
            off_q <= 6'h00;
            term_sel_q <= `TERM_OFF;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            off_q <= off_d;
            term_sel_q <= term_sel_d;
        end
    end

    // leveling feedback, one cycle after the strobe edge
    leveling_feedback #(
        .DATA_W(DATA_W)
    ) u_fb (
        .clock(clock),
        .rstn(rstn),
        .leveling_en(leveling_en),
        .strobe_rise(strobe_rise),
        .clk_level(clk_level),
        .fb_data_q(fb_data),
        .fb_oe_q(fb_oe)
    );
endmodule // dyn_term

// ---- bench/dyn_term_assertions.sv ----
`timescale 1ns/1ps
module dyn_term_assertions #(parameter DATA_W = 8) (
    input wire clock, rstn, term_ctrl, write_cmd, four_beat_chop,
    input wire dyn_term_en, leveling_en, strobe_rise, clk_level, fb_oe,
    input wire [1:0] term_sel_q,
    input wire [DATA_W-1:0] fb_data
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // a taken write; the bench fixes write latency at five
    wire wr = write_cmd && term_ctrl && dyn_term_en && !leveling_en && term_sel_q != 2'h2;
    wr_switch_a: assert property (wr |=> (term_sel_q != 2'h2)[*3] ##1 term_sel_q == 2'h2)
        else $error("write termination timing");
    full_span_a: assert property (wr && !four_beat_chop |-> ##4 (term_sel_q == 2'h2)[*6] ##1 term_sel_q != 2'h2)
        else $error("full write span");
    chop_span_a: assert property (wr && four_beat_chop |-> ##4 (term_sel_q == 2'h2)[*4] ##1 term_sel_q != 2'h2)
        else $error("chop write span");
    dyn_off_a: assert property (!dyn_term_en |=> term_sel_q != 2'h2)
        else $error("switch while disabled");
    lvl_off_a: assert property (leveling_en |=> term_sel_q != 2'h2)
        else $error("switch while leveling");
    fb_enable_a: assert property (1'b1 |=> fb_oe == $past(leveling_en))
        else $error("feedback enable");
    fb_level_a: assert property (leveling_en && strobe_rise |=> fb_data == {DATA_W{$past(clk_level)}})
        else $error("feedback level");
    fb_hold_a: assert property ((leveling_en && !strobe_rise)[*2] |=> $stable(fb_data))
        else $error("feedback not held");
endmodule // dyn_term_assertions

// ---- bench/ctrl_model.sv ----
`timescale 1ns/1ps
// far-side controller; every call starts just after a falling edge
module ctrl_model (
    input wire clock,
    output reg term_ctrl = 1'b0,
    output reg write_cmd = 1'b0,
    output reg four_beat_chop = 1'b0,
    output reg strobe_rise = 1'b0,
    output reg clk_level = 1'b0
);
    // control held eleven clocks, past both minimums, counted in edges
    task write_burst(input chop);
        begin
            term_ctrl = 1'b1;
            write_cmd = 1'b1;
            four_beat_chop = chop;
            @(negedge clock) write_cmd = 1'b0;
            four_beat_chop = !chop; // released: show the inverse
            fork
                begin
                    repeat (10) @(negedge clock);
                    term_ctrl = 1'b0;
                end
            join_none
        end
    endtask
    // one strobe; the level flips after so a stale capture shows
    task strobe(input lvl);
        begin
            strobe_rise = 1'b1;
            clk_level = lvl;
            @(negedge clock) strobe_rise = 1'b0;
            clk_level = !lvl;
        end
    endtask
endmodule // ctrl_model

// ---- bench/dyn_term_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module dyn_term_tb;
    reg clock = 1'b0, rstn = 1'b0, dyn_term_en = 1'b1, leveling_en = 1'b0;
    wire term_ctrl, write_cmd, four_beat_chop, strobe_rise, clk_level, fb_oe;
    wire [1:0] term_sel_q;
    wire [7:0] fb_data;
    int bad_count = 0, n_tests = 0, i;
    initial forever #50 clock = !clock;
    ctrl_model ctrl_model_inst (.*);
    dyn_term dyn_term_inst (.*, .column_write_latency(6'h05), .additive_latency(6'h00));
    task wrap_up;
        begin
            if (bad_count == 0 && n_tests > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // one write, then each cycle; n is the write span, zero if gated
    task burst(input chop, input int n);
        begin
            @(negedge clock) ctrl_model_inst.write_burst(chop);
            for (i = 1; i <= 11; i++) begin
                @(negedge clock);
                `CHK(term_sel_q == 2'h2, i >= 3 && i < 3 + n)
            end
        end
    endtask
    task level(input lvl);
        begin
            ctrl_model_inst.strobe(lvl);
            repeat (3) @(negedge clock);
            `CHK(fb_data, {8{lvl}})
            `CHK(fb_oe, 1'b1)
        end
    endtask
    initial begin
        repeat (12) @(negedge clock);
        rstn = 1'b1;
        burst(1'b0, 6);
        burst(1'b1, 4);
        dyn_term_en = 1'b0;
        burst(1'b0, 0);
        dyn_term_en = 1'b1;
        leveling_en = 1'b1;
        burst(1'b0, 0);
        repeat (40) @(negedge clock);
        level(1'b1);
        level(1'b0);
        wrap_up;
    end
    // run needs about 112 clocks
    initial begin
        #100000 bad_count++;
        wrap_up;
    end
endmodule // dyn_term_tb
bind dyn_term dyn_term_assertions #(.DATA_W(DATA_W)) dyn_term_assertions_inst (.*);
